// [rtl/swt_pkg.sv]
// Purpose: constants for the sleep wake timer and battery monitor
// Assumes: 200 MHz system clock, 32.768 kHz slow source sampled as a pin
// Notes:   register offsets are byte addresses on the register port
//
// Behaviour
// - battery code is 5-bit, 50 mV per step
// - detector powered 250 us every second
// - low-battery flag after four consecutive low readings
// - low-battery enable gates interrupt pin
// - host reads latest level, upper bits zero
// - detector in sleep starts slow RC oscillator unless crystal selected
// - wake timer runs in sleep if armed
// - period is M times two to (5+R-D) ticks
// - expiry with enable asserts interrupt pin
// - count readable as two bytes, high first
// - enabled expiry pulls pin and leaves sleep
// - disabled expiry sets wake flag and pulses wake pin function, pin stays high
// - external crystal select retimes all slow logic
package swt_pkg;

    // ======================================================
    // register offsets
    localparam logic [6:0] SWT_ADDR_STATUS1   = 7'h03;
    localparam logic [6:0] SWT_ADDR_STATUS2   = 7'h04;
    localparam logic [6:0] SWT_ADDR_PER_EXP   = 7'h14;
    localparam logic [6:0] SWT_ADDR_MANT_HI   = 7'h15;
    localparam logic [6:0] SWT_ADDR_MANT_LO   = 7'h16;
    localparam logic [6:0] SWT_ADDR_COUNT_HI  = 7'h17;
    localparam logic [6:0] SWT_ADDR_COUNT_LO  = 7'h18;
    localparam logic [6:0] SWT_ADDR_THRESHOLD = 7'h1a;
    localparam logic [6:0] SWT_ADDR_LEVEL     = 7'h1b;

    // ======================================================
    // field positions and reset values
    localparam int SWT_STAT_WAKE_BIT   = 3;
    localparam int SWT_STAT_LOWBAT_BIT = 2;
    localparam logic [5:0] SWT_PER_EXP_RESET   = 6'h00;
    localparam logic [15:0] SWT_MANT_RESET     = 16'h0000;
    localparam logic [4:0] SWT_THRESHOLD_RESET = 5'h14;
    localparam logic [4:0] SWT_LEVEL_RESET     = 5'h00;

    // ======================================================
    // timing
    localparam int SWT_CLK_MHZ        = 200;
    localparam int SWT_MEAS_TIME_US   = 250;
    localparam int SWT_MEAS_CYCLES    = SWT_MEAS_TIME_US * SWT_CLK_MHZ;
    localparam int SWT_SLOW_HZ        = 32768;
    localparam int SWT_MEAS_PERIOD_S  = 1;
    localparam int SWT_MEAS_PERIOD_TK = SWT_MEAS_PERIOD_S * SWT_SLOW_HZ;
    localparam logic [4:0] SWT_PRESC_BASE_SHIFT = 5'd5;
    localparam logic [2:0] SWT_LOWBAT_CONSEC    = 3'd4;

endpackage : swt_pkg

// [rtl/swt_top.sv]
// Purpose: wake timer and periodic battery monitor with interrupt pin
// Assumes: slow oscillator, crystal and battery code arrive as pins
// Notes:   all state lives in one struct registered on clk
`timescale 1ns/1ps

module swt_top #(
    parameter logic [15:0] MEAS_CYCLES    = 16'(swt_pkg::SWT_MEAS_CYCLES),
    parameter logic [15:0] MEAS_PERIOD_TK = 16'(swt_pkg::SWT_MEAS_PERIOD_TK)
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       sleep_mode,
    input  wire logic       lowbat_enable,
    input  wire logic       wake_timer_enable,
    input  wire logic       ext_slow_xtal_select,
    input  wire logic       wake_irq_enable,
    input  wire logic       lowbat_irq_enable,
    input  wire logic       rc_osc_clk,
    input  wire logic       gpio_pin_zero_in,
    input  wire logic [4:0] battery_code,
    output logic            irq_n_pin,
    output logic            lbd_power_on,
    output logic            rc_osc_enable,
    output logic            gpio_pin_zero_xtal_mode,
    output logic            wake_exit_sleep,
    output logic            wake_expired_pulse
);

    // ======================================================
    // state
    typedef struct packed {
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
        logic        xt_s1;
        logic        xt_s2;
        logic        xt_s3;
        logic [4:0]  bat_s1;
        logic [4:0]  bat_s2;
        logic        sleep_prev;
        logic        armed;
        logic [20:0] presc;
        logic [15:0] wcount;
        logic [5:0]  per_exp;
        logic [15:0] mant;
        logic [4:0]  thresh;
        logic [4:0]  level;
        logic [15:0] sec_cnt;
        logic        meas_on;
        logic [15:0] meas_cnt;
        logic [2:0]  consec;
        logic        wake_flag;
        logic        lowbat_flag;
        logic        irq_n;
        logic [7:0]  rdata;
        logic        exit_sleep;
        logic        expired;
        logic        osc_en;
    } swt_state_type;

    swt_state_type state_q;
    swt_state_type state_d;

    logic        slow_tick;
    logic        run;
    logic [4:0]  shift;
    logic [20:0] presc_lim;
    logic        expire;
    logic        meas_done;
    logic        low_now;
    logic        read_status;

    // ======================================================
    // slow tick from selected source
    always_comb
    begin
        if (ext_slow_xtal_select)
        begin
            slow_tick = state_q.xt_s2 & ~state_q.xt_s3;
        end
        else
        begin
            slow_tick = state_q.rc_s2 & ~state_q.rc_s3;
        end
    end

    // wake prescaler limit: 2^(5+R-D) ticks per mantissa step
    assign shift = SWT_SHIFT_CALC(state_q.per_exp);
    assign presc_lim = (21'(1) << shift) - 21'(1);
    // runs awake, or in sleep only when armed at entry
    assign run = wake_timer_enable & (~sleep_mode | state_q.armed);
    assign expire = run & slow_tick & (state_q.presc == presc_lim)
                  & ((state_q.wcount + 16'(1)) >= state_q.mant);
    assign meas_done = state_q.meas_on
                     & (state_q.meas_cnt == MEAS_CYCLES - 16'(1));
    assign low_now = state_q.bat_s2 < state_q.thresh;
    assign read_status = reg_re & (reg_addr == swt_pkg::SWT_ADDR_STATUS2);

    function automatic logic [4:0] SWT_SHIFT_CALC(input logic [5:0] pe);
        SWT_SHIFT_CALC = swt_pkg::SWT_PRESC_BASE_SHIFT + {1'b0, pe[5:2]}
                       - {3'b000, pe[1:0]};
    endfunction : SWT_SHIFT_CALC

    // ======================================================
    // next state
    always_comb
    begin
        state_d = state_q;
        // synchronisers
        state_d.rc_s1  = rc_osc_clk;
        state_d.rc_s2  = state_q.rc_s1;
        state_d.rc_s3  = state_q.rc_s2;
        state_d.xt_s1  = gpio_pin_zero_in;
        state_d.xt_s2  = state_q.xt_s1;
        state_d.xt_s3  = state_q.xt_s2;
        state_d.bat_s1 = battery_code;
        state_d.bat_s2 = state_q.bat_s1;
        state_d.exit_sleep = 1'b0;
        state_d.expired    = 1'b0;

        // arm wake timer on sleep entry
        state_d.sleep_prev = sleep_mode;
        if (sleep_mode & ~state_q.sleep_prev)
        begin
            state_d.armed = wake_timer_enable;
        end
        else if (~sleep_mode)
        begin
            state_d.armed = 1'b0;
        end

        // wake timer counting
        if (~run)
        begin
            state_d.presc  = '0;
            state_d.wcount = '0;
        end
        else if (slow_tick)
        begin
            if (state_q.presc == presc_lim)
            begin
                state_d.presc = '0;
                if (expire)
                begin
                    state_d.wcount = '0;
                end
                else
                begin
                    state_d.wcount = state_q.wcount + 16'(1);
                end
            end
            else
            begin
                state_d.presc = state_q.presc + 21'(1);
            end
        end

        // expiry effects
        if (expire)
        begin
            state_d.expired = 1'b1;
            if (wake_irq_enable)
            begin
                state_d.exit_sleep = sleep_mode;
            end
        end

        // battery measurement scheduling
        if (~lowbat_enable)
        begin
            state_d.sec_cnt  = '0;
            state_d.meas_on  = 1'b0;
            state_d.meas_cnt = '0;
            state_d.consec   = '0;
        end
        else
        begin
            if (slow_tick)
            begin
                if (state_q.sec_cnt == MEAS_PERIOD_TK - 16'(1))
                begin
                    state_d.sec_cnt  = '0;
                    state_d.meas_on  = 1'b1;
                    state_d.meas_cnt = '0;
                end
                else
                begin
                    state_d.sec_cnt = state_q.sec_cnt + 16'(1);
                end
            end
            if (state_q.meas_on)
            begin
                state_d.meas_cnt = state_q.meas_cnt + 16'(1);
            end
            if (meas_done)
            begin
                state_d.meas_on = 1'b0;
                state_d.level   = state_q.bat_s2;
                if (low_now)
                begin
                    if (state_q.consec != swt_pkg::SWT_LOWBAT_CONSEC)
                    begin
                        state_d.consec = state_q.consec + 3'(1);
                    end
                end
                else
                begin
                    state_d.consec = '0;
                end
            end
        end

        // flags: status read clears, a new event wins
        if (read_status)
        begin
            state_d.wake_flag   = 1'b0;
            state_d.lowbat_flag = 1'b0;
        end
        if (expire)
        begin
            state_d.wake_flag = 1'b1;
        end
        if (meas_done & low_now
            & (state_q.consec >= swt_pkg::SWT_LOWBAT_CONSEC - 3'(1)))
        begin
            state_d.lowbat_flag = 1'b1;
        end

        // interrupt pin low while an enabled flag is pending
        state_d.irq_n = ~((state_d.wake_flag & wake_irq_enable)
                        | (state_d.lowbat_flag & lowbat_irq_enable));

        // slow RC oscillator request in sleep
        state_d.osc_en = sleep_mode & ~ext_slow_xtal_select
                       & (lowbat_enable | state_q.armed);

        // register writes
        if (reg_we)
        begin
            unique case (reg_addr)
                swt_pkg::SWT_ADDR_PER_EXP:
                    state_d.per_exp = reg_wdata[5:0];
                swt_pkg::SWT_ADDR_MANT_HI:
                    state_d.mant[15:8] = reg_wdata;
                swt_pkg::SWT_ADDR_MANT_LO:
                    state_d.mant[7:0] = reg_wdata;
                swt_pkg::SWT_ADDR_THRESHOLD:
                    state_d.thresh = reg_wdata[4:0];
                default:
                    state_d.thresh = state_d.thresh;
            endcase
        end

        // register reads, data held until next read
        if (reg_re)
        begin
            unique case (reg_addr)
                swt_pkg::SWT_ADDR_STATUS2:
                begin
                    state_d.rdata = 8'h00;
                    state_d.rdata[swt_pkg::SWT_STAT_WAKE_BIT] =
                        state_q.wake_flag;
                    state_d.rdata[swt_pkg::SWT_STAT_LOWBAT_BIT] =
                        state_q.lowbat_flag;
                end
                swt_pkg::SWT_ADDR_PER_EXP:
                    state_d.rdata = {2'b00, state_q.per_exp};
                swt_pkg::SWT_ADDR_MANT_HI:
                    state_d.rdata = state_q.mant[15:8];
                swt_pkg::SWT_ADDR_MANT_LO:
                    state_d.rdata = state_q.mant[7:0];
                swt_pkg::SWT_ADDR_COUNT_HI:
                    state_d.rdata = state_q.wcount[15:8];
                swt_pkg::SWT_ADDR_COUNT_LO:
                    state_d.rdata = state_q.wcount[7:0];
                swt_pkg::SWT_ADDR_THRESHOLD:
                    state_d.rdata = {3'b000, state_q.thresh};
                swt_pkg::SWT_ADDR_LEVEL:
                    state_d.rdata = {3'b000, state_q.level};
                default:
                    state_d.rdata = 8'h00;
            endcase
        end
    end

    // ======================================================
    // state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q         <= '0;
            state_q.per_exp <= swt_pkg::SWT_PER_EXP_RESET;
            state_q.mant    <= swt_pkg::SWT_MANT_RESET;
            state_q.thresh  <= swt_pkg::SWT_THRESHOLD_RESET;
            state_q.level   <= swt_pkg::SWT_LEVEL_RESET;
            state_q.irq_n   <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ======================================================
    // outputs
    assign reg_rdata               = state_q.rdata;
    assign irq_n_pin               = state_q.irq_n;
    assign lbd_power_on            = state_q.meas_on;
    assign rc_osc_enable           = state_q.osc_en;
    assign gpio_pin_zero_xtal_mode = ext_slow_xtal_select;
    assign wake_exit_sleep         = state_q.exit_sleep;
    assign wake_expired_pulse      = state_q.expired;

endmodule : swt_top

// [test/swt_top_sva.sv]
// Purpose: port checker for swt_top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the top after the module
`timescale 1ns/1ps

module swt_chk #(
    parameter logic [15:0] MEAS_CYCLES = 16'h0008
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [6:0] reg_addr,
    input wire logic       reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic       sleep_mode,
    input wire logic       lowbat_enable,
    input wire logic       wake_irq_enable,
    input wire logic       lowbat_irq_enable,
    input wire logic       ext_slow_xtal_select,
    input wire logic       irq_n_pin,
    input wire logic       lbd_power_on,
    input wire logic       rc_osc_enable,
    input wire logic       gpio_pin_zero_xtal_mode,
    input wire logic       wake_exit_sleep,
    input wire logic       wake_expired_pulse
);
    logic [15:0] on_cnt_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // =========================================
    // length of the running power window
    always_ff @(posedge clk)
        on_cnt_q <= lbd_power_on ? on_cnt_q + 16'h0001 : 16'h0000;

    // =========================================
    // port relations
    a_meas_window: assert property ($fell(lbd_power_on) &&
        $past(lowbat_enable) |-> on_cnt_q == MEAS_CYCLES)
        else $error("power window length wrong");
    a_meas_cause: assert property ($rose(lbd_power_on) |->
        $past(lowbat_enable)) else $error("power without enable");
    a_rc_request: assert property ((sleep_mode && lowbat_enable &&
        !ext_slow_xtal_select)[*2] |-> rc_osc_enable)
        else $error("slow oscillator not requested");
    a_rc_xtal_off: assert property (ext_slow_xtal_select[*2] |->
        !rc_osc_enable) else $error("slow oscillator on with crystal");
    a_wake_irq: assert property (wake_expired_pulse &&
        $past(wake_irq_enable) |-> !irq_n_pin)
        else $error("expiry left pin high");
    a_wake_exit: assert property (wake_exit_sleep |->
        wake_expired_pulse && $past(wake_irq_enable) && $past(sleep_mode))
        else $error("sleep exit without enabled expiry");
    a_pulse_single: assert property (wake_expired_pulse |=>
        !wake_expired_pulse) else $error("expiry pulse too long");
    a_irq_quiet: assert property ((!wake_irq_enable &&
        !lowbat_irq_enable)[*2] |-> irq_n_pin)
        else $error("pin driven with enables clear");
    a_status_clear: assert property (reg_re &&
        reg_addr == swt_pkg::SWT_ADDR_STATUS2 |=> irq_n_pin ||
        wake_expired_pulse || $fell(lbd_power_on))
        else $error("pin held after status read");
    a_level_bits: assert property (reg_re &&
        reg_addr == swt_pkg::SWT_ADDR_LEVEL |=> reg_rdata[7:5] == 3'b000)
        else $error("level upper bits set");
    a_xtal_mode: assert property (gpio_pin_zero_xtal_mode ==
        ext_slow_xtal_select) else $error("pin zero mode mismatch");
endmodule : swt_chk

bind swt_top swt_chk #(.MEAS_CYCLES(MEAS_CYCLES)) u_chk (
    .clk, .resetn, .reg_addr, .reg_re, .reg_rdata, .sleep_mode,
    .lowbat_enable, .wake_irq_enable, .lowbat_irq_enable,
    .ext_slow_xtal_select, .irq_n_pin, .lbd_power_on, .rc_osc_enable,
    .gpio_pin_zero_xtal_mode, .wake_exit_sleep, .wake_expired_pulse
);

// [test/swt_host_model.sv]
// Purpose: host controller model on the register port
// Assumes: strobes change just after a rising edge
// Notes:   the bench calls its tasks
`timescale 1ns/1ps

module swt_host_model (
    input  wire logic       clk,
    output logic      [6:0] reg_addr,
    output logic            reg_we,
    output logic            reg_re,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // =========================================
    // idle port at time zero
    initial
    begin
        reg_addr  = 7'h00;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
        reg_wdata = 8'h00;
    end

    // one-cycle write strobe
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data settled after the taking edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // confirm an interrupt by reading both status bytes
    task automatic service(output logic [7:0] st);
        logic [7:0] s1;
        rd(swt_pkg::SWT_ADDR_STATUS1, s1);
        rd(swt_pkg::SWT_ADDR_STATUS2, st);
    endtask : service
endmodule : swt_host_model

// [test/test_sleep_wake_timer_and_battery_monitor.sv]
// Purpose: self-checking bench for swt_top
// Assumes: slow sources sped up to 16 clk a period
// Notes:   measurement counts shortened by parameters
`timescale 1ns/1ps

module test_sleep_wake_timer_and_battery_monitor;
    logic       clk, resetn, reg_we, reg_re, sleep_mode, lowbat_enable;
    logic       wake_timer_enable, ext_slow_xtal_select, wake_irq_enable;
    logic       lowbat_irq_enable, rc_osc_clk, gpio_pin_zero_in, irq_n_pin;
    logic       lbd_power_on, rc_osc_enable, gpio_pin_zero_xtal_mode;
    logic       wake_exit_sleep, wake_expired_pulse;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] battery_code;
    logic [2:0] div_q;
    int         bad_count, samples_checked;

    swt_top #(.MEAS_CYCLES(16'h0008), .MEAS_PERIOD_TK(16'h0004)) dut (
        .clk, .resetn, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata,
        .sleep_mode, .lowbat_enable, .wake_timer_enable,
        .ext_slow_xtal_select, .wake_irq_enable, .lowbat_irq_enable,
        .rc_osc_clk, .gpio_pin_zero_in, .battery_code, .irq_n_pin,
        .lbd_power_on, .rc_osc_enable, .gpio_pin_zero_xtal_mode,
        .wake_exit_sleep, .wake_expired_pulse
    );
    swt_host_model host (
        .clk, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata
    );

    // =========================================
    // clocks: the unused slow source stands still
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        div_q <= div_q + 3'h1;
        if (div_q == 3'h7 && ext_slow_xtal_select)
            gpio_pin_zero_in <= ~gpio_pin_zero_in;
        else if (div_q == 3'h7)
            rc_osc_clk <= ~rc_osc_clk;
    end

    // =========================================
    // checking and waiting helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // w 0: expiry pulse, else start of a power window
    task automatic wait_ev(input int w, output int n);
        logic prev;
        n = 0;
        do
        begin
            prev = lbd_power_on;
            @(posedge clk);
            #1 n++;
            if (n > 3000)
            begin
                bad_count++;
                final_report();
            end
        end while (!(w == 0 ? wake_expired_pulse === 1'b1
                     : lbd_power_on === 1'b1 && prev !== 1'b1));
    endtask : wait_ev

    // =========================================
    // scenarios
    task automatic t_regs;
        logic [6:0] a [7] = '{7'h14, 7'h15, 7'h16, 7'h1a, 7'h1b, 7'h17, 7'h30};
        logic [7:0] r [7] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00};
        logic [7:0] w [7] = '{8'h3f, 8'ha5, 8'h5a, 8'h0a, 8'h55, 8'hff, 8'hff};
        logic [7:0] e [7] = '{8'h3f, 8'ha5, 8'h5a, 8'h0a, 8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 7; i++)
        begin
            host.rd(a[i], d);
            chk(16'(d), 16'(r[i]));
            host.wr(a[i], w[i]);
            host.rd(a[i], d);
            chk(16'(d), 16'(e[i]));
        end
        host.wr(swt_pkg::SWT_ADDR_MANT_HI, 8'h00);
    endtask : t_regs

    task automatic t_wake(input logic [7:0] per, input logic [7:0] mant,
                          input int ticks, input logic wirq, input logic xt);
        int         n;
        logic [7:0] d;
        host.wr(swt_pkg::SWT_ADDR_PER_EXP, per);
        host.wr(swt_pkg::SWT_ADDR_MANT_LO, mant);
        @(posedge clk);
        ext_slow_xtal_select <= xt;
        wake_irq_enable      <= wirq;
        wake_timer_enable    <= 1'b1;
        @(posedge clk);
        sleep_mode <= 1'b1;
        wait_ev(0, n);
        wait_ev(0, n);
        chk(16'(n), 16'(ticks * 16));
        chk(16'(wake_exit_sleep), 16'(wirq));
        chk(16'(irq_n_pin), 16'(!wirq));
        chk(16'(rc_osc_enable), 16'(!xt));
        chk(16'(gpio_pin_zero_xtal_mode), 16'(xt));
        host.rd(swt_pkg::SWT_ADDR_COUNT_HI, d);
        chk(16'(d), 16'h0000);
        host.service(d);
        chk(16'(d & 8'h08), 16'h0008);
        chk(16'(irq_n_pin), 16'h0001);
        @(posedge clk);
        wake_timer_enable    <= 1'b0;
        sleep_mode           <= 1'b0;
        ext_slow_xtal_select <= 1'b0;
    endtask : t_wake

    // timer enabled only after sleep entry must stay quiet
    task automatic t_gate;
        int hits;
        hits = 0;
        host.wr(swt_pkg::SWT_ADDR_PER_EXP, 8'h03);
        host.wr(swt_pkg::SWT_ADDR_MANT_LO, 8'h02);
        @(posedge clk);
        sleep_mode <= 1'b1;
        @(posedge clk);
        wake_timer_enable <= 1'b1;
        repeat (400)
        begin
            @(posedge clk);
            #1 if (wake_expired_pulse !== 1'b0) hits++;
        end
        chk(16'(hits), 16'h0000);
        wake_timer_enable <= 1'b0;
        sleep_mode        <= 1'b0;
    endtask : t_gate

    task automatic t_lowbat;
        int         n;
        logic [7:0] d;
        host.wr(swt_pkg::SWT_ADDR_THRESHOLD, 8'h10);
        @(posedge clk);
        battery_code      <= 5'h08;
        lowbat_irq_enable <= 1'b1;
        lowbat_enable     <= 1'b1;
        sleep_mode        <= 1'b1;
        for (int i = 1; i <= 4; i++)
        begin
            wait_ev(1, n);
            repeat (12) @(posedge clk);
            chk(16'(irq_n_pin), 16'(i < 4));
        end
        host.rd(swt_pkg::SWT_ADDR_LEVEL, d);
        chk(16'(d), 16'h0008);
        chk(16'(rc_osc_enable), 16'h0001);
        host.service(d);
        chk(16'(d & 8'h04), 16'h0004);
        chk(16'(irq_n_pin), 16'h0001);
        // low reading with its enable clear: flag kept, pin left high
        lowbat_irq_enable <= 1'b0;
        wait_ev(1, n);
        repeat (12) @(posedge clk);
        chk(16'(irq_n_pin), 16'h0001);
        host.service(d);
        chk(16'(d & 8'h04), 16'h0004);
        battery_code      <= 5'h1f;
        lowbat_irq_enable <= 1'b1;
        wait_ev(1, n);
        repeat (12) @(posedge clk);
        host.rd(swt_pkg::SWT_ADDR_LEVEL, d);
        chk(16'(d), 16'h001f);
        chk(16'(irq_n_pin), 16'h0001);
        lowbat_enable <= 1'b0;
        sleep_mode    <= 1'b0;
    endtask : t_lowbat

    // =========================================
    // main sequence
    initial
    begin
        {clk, resetn, sleep_mode, lowbat_enable, wake_timer_enable} = '0;
        {ext_slow_xtal_select, wake_irq_enable, lowbat_irq_enable} = '0;
        {rc_osc_clk, gpio_pin_zero_in, div_q} = '0;
        battery_code = 5'h1f;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_wake(8'h03, 8'h02, 8, 1'b1, 1'b0);
        t_wake(8'h04, 8'h01, 64, 1'b0, 1'b1);
        t_gate();
        t_lowbat();
        final_report();
    end
endmodule : test_sleep_wake_timer_and_battery_monitor
